// ==== hw/ive_pkg.sv ====
// Package: constants and carriers for the receive video enhancement control block
package ive_pkg;

  // Register offsets in the extension space
  localparam logic [11:0] IVE_SET_OFS = 12'hA80;
  localparam logic [11:0] IVE_CLR_OFS = 12'hA84;
  localparam logic [31:0] IVE_RESET = 32'h0000_0000;
  localparam logic [31:0] IVE_WR_MASK = 32'h0000_3333;

  // Field layout: one nibble per context
  localparam int IVE_CTX_STRIDE = 4;
  localparam int IVE_HDR_STRIP_POS = 0;
  localparam int IVE_FRAME_SYNC_POS = 1;

  // Receive context control registers, one per context
  localparam logic [11:0] IVE_CTX_CTRL_OFS0 = 12'h400;
  localparam logic [11:0] IVE_CTX_CTRL_STRIDE = 12'h020;
  localparam int IVE_CTRL_ACTIVE_POS = 10;
  localparam int IVE_CTRL_RUN_POS = 15;
  localparam int IVE_CTRL_ISOCH_HDR_POS = 30;

  // Stream framing
  localparam logic [7:0] IVE_FS_BYTE0 = 8'h1F;
  localparam logic [3:0] IVE_FS_NIB1 = 4'h7;
  localparam logic [1:0] IVE_HDR_QUADS = 2'h2;
  localparam logic [1:0] IVE_DESC_B_SYNC = 2'h1;

  typedef struct packed {
    logic sop;
    logic [31:0] data;
  } ive_quad_s;

  typedef struct packed {
    logic buffer_fill;
    logic [1:0] b;
    logic at_frame_start;
  } ive_desc_s;

  typedef enum logic {IVE_WAIT_FRAME, IVE_FILL} ive_sync_e;

endpackage : ive_pkg

// ==== hw/ive_set_clr_reg.sv ====
// Set/clear register storage with a mask of writable bits
`timescale 1ns/100ps
module ive_set_clr_reg
  import ive_pkg::*;
#(
  parameter int W = 32,
  parameter logic [W-1:0] MASK = '1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Write strobes
  input wire logic set_we,
  input wire logic clr_we,
  input wire logic [W-1:0] wdata,
  // Current value
  output logic [W-1:0] value
);

  logic [W-1:0] next_value;

  always_comb begin
    next_value = value;
    if (set_we) begin
      next_value = next_value | wdata;
    end
    if (clr_we) begin
      next_value = next_value & ~wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      value <= RST;
    end else begin
      value <= next_value & MASK; // [R17] [R2]
    end
  end

endmodule : ive_set_clr_reg

// ==== hw/ive_rx_enhance_ctrl.sv ====
// Receive video enhancement control: set/clear register and per-context strip/frame sync
// Notes on behaviour
// (R1) Software changes this register only while the context's active and run bits are zero.
// (R2) Reserved bits 31-14, 11-10, 7-6 and 3-2 read as zero.
// (R3) Set alias A80h sets written ones, clear alias A84h clears; both read value.
// (R4) Context 0 strip enable (bit 0) drops the first two payload quadlets.
// (R5) Context 1 strip enable (bit 4) drops the first two payload quadlets.
// (R6) Context 2 strip enable (bit 8) drops the first two payload quadlets.
// (R7) Context 3 strip enable (bit 12) drops the first two payload quadlets.
// (R8) A strip enable counts only while the context's isochHeader bit is zero.
// (R9) Context 0 frame sync (bit 1): buffer-fill, b=01, align and branch on stray start.
// (R10) Context 1 frame sync (bit 5): same alignment and branch behaviour.
// (R11) Context 2 frame sync (bit 9): same alignment and branch behaviour.
// (R12) Context 3 frame sync (bit 13): same alignment and branch behaviour.
// (R13) Frame sync acts only when strip is on and isochHeader is zero.
// (R14) isochHeader comes from context control registers at 400h, 420h, 440h, 460h.
// (R15) Frame start: third quadlet begins with byte 1Fh then a byte with low nibble 7h.
// (R16) In frame sync, data is dropped until a frame start, then filling begins.
// (R17) Writes of one to reserved bits are ignored through either alias.
`timescale 1ns/100ps
module ive_rx_enhance_ctrl
  import ive_pkg::*;
#(
  parameter int NUM_CTX = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register access in the extension space
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Receive context control register values, context n at 400h + n*20h
  input wire logic [NUM_CTX-1:0][31:0] ctx_ctrl,
  // Received payload quadlets per context
  input wire logic [NUM_CTX-1:0] rx_valid,
  input wire ive_quad_s [NUM_CTX-1:0] rx_quad,
  // Current descriptor state per context
  input wire ive_desc_s [NUM_CTX-1:0] rx_desc,
  // Quadlets to store per context
  output logic [NUM_CTX-1:0] store_valid,
  output logic [NUM_CTX-1:0][31:0] store_data,
  // Branch to frameBranch, one-cycle pulse per context
  output logic [NUM_CTX-1:0] frame_branch,
  // Effective modes per context
  output logic [NUM_CTX-1:0] strip_active,
  output logic [NUM_CTX-1:0] sync_active
);

  logic [31:0] enh_value;
  logic addr_set;
  logic addr_clr;
  logic set_we;
  logic clr_we;
  logic [31:0] rd_value;

  // Picks a field bit of context ctx out of the enhancement word
  function automatic logic ctx_field(input logic [31:0] value, input int ctx, input int pos);
    ctx_field = value[ctx * IVE_CTX_STRIDE + pos];
  endfunction : ctx_field

  function automatic logic is_frame_start(input logic [31:0] quad);
    is_frame_start = (quad[31:24] == IVE_FS_BYTE0) && (quad[19:16] == IVE_FS_NIB1); // [R15]
  endfunction : is_frame_start

  // Only the header quadlets need telling apart, so the index sticks at three
  function automatic logic [1:0] advance_idx(input logic [1:0] idx);
    if (idx == 2'h3) begin
      advance_idx = 2'h3;
    end else begin
      advance_idx = idx + 2'h1;
    end
  endfunction : advance_idx

  function automatic logic addr_hit(input logic sel, input logic [11:0] addr,
                                    input logic [11:0] ofs);
    addr_hit = sel && (addr == ofs);
  endfunction : addr_hit

  assign addr_set = addr_hit(reg_sel, reg_addr, IVE_SET_OFS); // [R3]
  assign addr_clr = addr_hit(reg_sel, reg_addr, IVE_CLR_OFS); // [R3]
  assign set_we = addr_set && reg_wr; // [R3]
  assign clr_we = addr_clr && reg_wr; // [R3]

  // The block trusts software to leave running contexts alone; no interlock is built
  ive_set_clr_reg #(
    .W(32),
    .MASK(IVE_WR_MASK),
    .RST(IVE_RESET)
  ) u_enh_reg (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .set_we(set_we),
    .clr_we(clr_we),
    .wdata(reg_wdata),
    .value(enh_value)
  );

  // Unmapped addresses read as zero; reserved bits are masked again on the way out
  always_comb begin
    rd_value = IVE_RESET;
    if (addr_set || addr_clr) begin
      rd_value = enh_value & IVE_WR_MASK; // [R2] [R3]
    end
  end

  // Read data stays until the next read, so the host may pick it up late
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= IVE_RESET;
    end else if (reg_sel && reg_rd) begin
      reg_rdata <= rd_value;
    end
  end

  // One identical lane per receive context
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CTX; gi++) begin : g_ctx
      logic isoch_hdr;
      logic strip_en;
      logic sync_en;
      logic desc_sync;
      logic strip_on;
      logic sync_on;
      logic [1:0] quad_idx;
      logic [1:0] cur_idx;
      logic [1:0] next_idx;
      logic tag_quad;
      logic keep_pkt;
      logic start_now;
      logic stray_start;
      logic keep_now;
      logic pass;
      logic take;
      ive_sync_e sync_state;

      assign isoch_hdr = ctx_ctrl[gi][IVE_CTRL_ISOCH_HDR_POS]; // [R14]
      assign strip_en = ctx_field(enh_value, gi, IVE_HDR_STRIP_POS);
      assign sync_en = ctx_field(enh_value, gi, IVE_FRAME_SYNC_POS);
      assign desc_sync = rx_desc[gi].buffer_fill && (rx_desc[gi].b == IVE_DESC_B_SYNC);
      assign strip_on = strip_en && !isoch_hdr; // [R8]
      assign sync_on = sync_en && strip_on && desc_sync; // [R9] [R10] [R11] [R12] [R13]
      assign strip_active[gi] = strip_on;
      assign sync_active[gi] = sync_on;

      // Payload quadlet index, saturating once past the header
      assign cur_idx = rx_quad[gi].sop ? 2'h0 : quad_idx;
      assign next_idx = advance_idx(cur_idx);
      assign tag_quad = (cur_idx == IVE_HDR_QUADS);
      assign start_now = tag_quad && is_frame_start(rx_quad[gi].data);
      // A start tag while filling away from a frame boundary is out of place
      assign stray_start = start_now && (sync_state == IVE_FILL)
                           && !rx_desc[gi].at_frame_start;

      // Frame decision is made on quadlet 2, before anything of the packet is stored
      always_comb begin
        if (tag_quad) begin
          keep_now = start_now || (sync_state == IVE_FILL);
        end else begin
          keep_now = keep_pkt;
        end
      end

      // [R4] [R5] [R6] [R7] [R16]
      assign pass = (!strip_on || cur_idx >= IVE_HDR_QUADS) && (!sync_on || keep_now);
      assign take = rx_valid[gi] && pass;

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          quad_idx <= 2'h0;
        end else if (rx_valid[gi]) begin
          quad_idx <= next_idx;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          keep_pkt <= 1'b0;
        end else if (rx_valid[gi] && tag_quad) begin
          keep_pkt <= keep_now;
        end
      end

      // Losing any enable drops back to waiting for the next frame start
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          sync_state <= IVE_WAIT_FRAME;
        end else if (!sync_on) begin
          sync_state <= IVE_WAIT_FRAME;
        end else if (rx_valid[gi] && start_now) begin
          sync_state <= IVE_FILL; // [R16]
        end
      end

      // Registered so the branch lines up with the stored tag quadlet
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          frame_branch[gi] <= 1'b0;
        end else begin
          frame_branch[gi] <= rx_valid[gi] && sync_on && stray_start; // [R9] [R10] [R11] [R12]
        end
      end

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          store_valid[gi] <= 1'b0;
        end else begin
          store_valid[gi] <= take; // [R4] [R5] [R6] [R7]
        end
      end

      // Data holds its last value between stores; only store_valid marks a new quadlet
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          store_data[gi] <= 32'h0000_0000;
        end else if (take) begin
          store_data[gi] <= rx_quad[gi].data;
        end
      end
    end
  endgenerate

endmodule : ive_rx_enhance_ctrl

// ==== sim/ive_rx_enhance_ctrl_props.sv ====
// Checker for the receive video enhancement control block
`timescale 1ns/100ps
module ive_rx_enhance_ctrl_props
  import ive_pkg::*;
#(
  parameter int NUM_CTX = 4
) (
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Context side
  input wire logic [NUM_CTX-1:0][31:0] ctx_ctrl,
  input wire logic [NUM_CTX-1:0] rx_valid,
  input wire ive_quad_s [NUM_CTX-1:0] rx_quad,
  input wire ive_desc_s [NUM_CTX-1:0] rx_desc,
  input wire logic [NUM_CTX-1:0] store_valid,
  input wire logic [NUM_CTX-1:0][31:0] store_data,
  input wire logic [NUM_CTX-1:0] frame_branch,
  input wire logic [NUM_CTX-1:0] strip_active,
  input wire logic [NUM_CTX-1:0] sync_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic set_wr = reg_sel && reg_wr && reg_addr == IVE_SET_OFS;
  wire logic clr_wr = reg_sel && reg_wr && reg_addr == IVE_CLR_OFS;
  a_rsvd_zero: assert property ((reg_rdata & 32'hFFFF_CCCC) == 32'h0000_0000)
    else $error("reserved bits read as one");
  a_set_read: assert property (set_wr && reg_wdata[4] ##[1:2]
    reg_sel && reg_rd |=> reg_rdata[4])
    else $error("set alias did not set");
  a_clr_read: assert property (clr_wr && reg_wdata[4] ##[1:2]
    reg_sel && reg_rd |=> !reg_rdata[4])
    else $error("clear alias did not clear");
  a_unmap_zero: assert property (reg_sel && reg_rd && reg_addr != IVE_SET_OFS &&
    reg_addr != IVE_CLR_OFS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_strip_iso: assert property ((strip_active & {ctx_ctrl[3][30], ctx_ctrl[2][30],
    ctx_ctrl[1][30], ctx_ctrl[0][30]}) == 4'h0)
    else $error("strip active with header mode");
  a_sync_gate: assert property (sync_active[1] |-> strip_active[1] &&
    rx_desc[1].buffer_fill && rx_desc[1].b == 2'h1)
    else $error("frame sync without its conditions");
  a_strip_drop: assert property (rx_valid[2] && rx_quad[2].sop && strip_active[2] |=>
    !store_valid[2])
    else $error("first quadlet stored while stripping");
  a_branch_tag: assert property (frame_branch[0] |->
    $past(sync_active[0] && rx_valid[0] &&
    rx_quad[0].data[31:24] == 8'h1F && rx_quad[0].data[19:16] == 4'h7))
    else $error("branch without a frame start");
endmodule : ive_rx_enhance_ctrl_props
bind ive_rx_enhance_ctrl ive_rx_enhance_ctrl_props #(.NUM_CTX(NUM_CTX)) u_props (.core_clk,
  .reset_n, .reg_sel, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .ctx_ctrl,
  .rx_valid, .rx_quad, .rx_desc, .store_valid, .store_data, .frame_branch, .strip_active,
  .sync_active);

// ==== sim/ive_dma_model.sv ====
// Receive DMA context model: control registers and descriptor state
`timescale 1ns/100ps
module ive_dma_model
  import ive_pkg::*;
(
  // Modes chosen by the bench
  input wire logic [3:0] iso_hdr,
  input wire logic fill,
  input wire logic at_fs,
  // State seen by the block
  output logic [3:0][31:0] ctx_ctrl,
  output ive_desc_s [3:0] rx_desc
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // Contexts stay stopped so enhancement bits may change at any time
      ctx_ctrl[i] = 32'h0000_0000;
      ctx_ctrl[i][IVE_CTRL_ISOCH_HDR_POS] = iso_hdr[i];
      rx_desc[i] = '{fill, IVE_DESC_B_SYNC, at_fs};
    end
  end
endmodule : ive_dma_model

// ==== sim/tb.sv ====
// Self-checking bench for the receive video enhancement control block
`timescale 1ns/100ps
module tb;
  import ive_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic [3:0] rx_valid = 4'h0;
  logic [3:0] iso = 4'h0;
  logic [3:0] store_valid, frame_branch, strip_active, sync_active;
  logic fill = 1'b0;
  logic at_fs = 1'b0;
  logic [3:0][31:0] ctx_ctrl, store_data;
  ive_quad_s [3:0] rx_quad = '0;
  ive_desc_s [3:0] rx_desc;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] nst [4] = '{default: 8'h00};
  logic [7:0] nbr [4] = '{default: 8'h00};
  logic [7:0] bst [4], bbr [4];
  logic [31:0] fst [4];
  always #4 core_clk = ~core_clk;
  ive_dma_model dma_u (.iso_hdr(iso), .fill, .at_fs, .ctx_ctrl, .rx_desc);
  ive_rx_enhance_ctrl dut_u (.core_clk, .reset_n, .reg_sel, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .ctx_ctrl, .rx_valid, .rx_quad, .rx_desc, .store_valid,
    .store_data, .frame_branch, .strip_active, .sync_active);
  // Outputs stand one cycle, so count them at every edge
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (reset_n) begin
        nst[i] <= nst[i] + 8'(store_valid[i]);
        nbr[i] <= nbr[i] + 8'(frame_branch[i]);
      end
      // First quadlet stored since the current packet began
      if (reset_n && store_valid[i] && nst[i] == bst[i]) begin
        fst[i] <= store_data[i];
      end
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Write (w=1) or read and compare with d (w=0)
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_sel <= 1'b1;
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_sel <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!w) chk(reg_rdata, d);
  endtask : acc
  // One four-quadlet packet on every context at once
  task automatic send(input logic [31:0] q2, input logic [7:0] est, input logic [7:0] ebr);
    bst = nst;
    bbr = nbr;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      rx_valid <= 4'hF;
      for (int i = 0; i < 4; i++) rx_quad[i] <= '{k == 0, k == 2 ? q2 : 32'(k)};
    end
    @(posedge core_clk);
    rx_valid <= 4'h0;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      chk(32'(nst[i] - bst[i]), iso[i] ? 32'h4 : 32'(est));
      chk(32'(nbr[i] - bbr[i]), 32'(ebr));
      if (iso[i] || est != 8'h0) begin
        chk(fst[i], iso[i] ? 32'h0000_0000 : q2);
        chk(store_data[i], 32'h0000_0003);
      end
    end
  endtask : send
  task automatic t_regs;
    acc(0, IVE_SET_OFS, 32'h0000_0000);
    acc(1, IVE_SET_OFS, 32'hFFFF_FFFF);
    acc(0, IVE_CLR_OFS, 32'h0000_3333);
    acc(1, IVE_CLR_OFS, 32'hFFFF_DDDD);
    acc(0, IVE_SET_OFS, 32'h0000_2222);
    acc(0, 12'hA88, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_strip;
    acc(1, IVE_CLR_OFS, 32'h0000_2222);
    acc(1, IVE_SET_OFS, 32'h0000_1111);
    @(posedge core_clk);
    iso <= 4'h5;
    send(32'h0000_5A5A, 8'h2, 8'h0);
    chk(32'(strip_active), 32'h0000_000A);
    $display("test strip done");
  endtask : t_strip
  task automatic t_sync;
    @(posedge core_clk);
    iso <= 4'h0;
    fill <= 1'b1;
    acc(1, IVE_SET_OFS, 32'h0000_2222);
    send(32'h0000_0000, 8'h0, 8'h0);
    send(32'h1FA7_0000, 8'h2, 8'h0);
    send(32'h1F07_0000, 8'h2, 8'h1);
    @(posedge core_clk);
    at_fs <= 1'b1;
    send(32'h1F07_0000, 8'h2, 8'h0);
    chk(32'(sync_active), 32'h0000_000F);
    acc(1, IVE_CLR_OFS, 32'h0000_1111);
    chk(32'(sync_active), 32'h0000_0000);
    acc(1, IVE_SET_OFS, 32'h0000_1111);
    @(posedge core_clk);
    fill <= 1'b0;
    @(posedge core_clk);
    chk(32'(sync_active), 32'h0000_0000);
    $display("test sync done");
  endtask : t_sync
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs;
    t_strip;
    t_sync;
    end_of_test;
  end
  // Tests need well under a thousand cycles
  initial begin
    #100000;
    failures++;
    end_of_test;
  end
endmodule : tb
